// ---- core/aeac_pkg.sv ----
// Purpose: shared constants for the active energy accumulator block
// Assumes: 24-bit register data, 4-bit word address on the register port
// Notes:   offsets, field positions and reset values live here; the step period comes from the 2-bit phase_q in aeac_top
package aeac_pkg;

  // ----------------------------------------------------------------------
  // register map (word addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_ENERGY_CLR  = 4'h0;
  localparam logic [3:0] ADDR_ENERGY_KEEP = 4'h1;
  localparam logic [3:0] ADDR_DIVISOR     = 4'h2;
  localparam logic [3:0] ADDR_OFFSET      = 4'h3;
  localparam logic [3:0] ADDR_NUMERATOR   = 4'h4;
  localparam logic [3:0] ADDR_DENOMINATOR = 4'h5;
  localparam logic [3:0] ADDR_GAIN        = 4'h6;
  localparam logic [3:0] ADDR_MODE        = 4'h7;
  localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h8;
  localparam logic [3:0] ADDR_IRQ_ENABLE  = 4'h9;
  localparam logic [3:0] ADDR_WAVEFORM    = 4'hA;

  // ----------------------------------------------------------------------
  // widths and field layout
  // ----------------------------------------------------------------------
  localparam int DATA_W    = 24;
  localparam int ADDR_W    = 4;
  localparam int ACC_W     = 48;
  localparam int ENERGY_W  = 24;
  localparam int DIV_W     = 8;
  localparam int OFFSET_W  = 16;
  localparam int SCALE_W   = 12;
  localparam int GAIN_W    = 12;
  localparam int GAIN_FRAC = 12;
  localparam int OFS_FRAC  = 8;
  localparam int IRQ_W     = 4;
  localparam int MODE_SEL_LO  = 13;
  localparam int MODE_RATE_LO = 11;
  localparam logic [1:0] WAVE_SEL_POWER = 2'b00;

  // interrupt status / enable bit positions
  localparam int IRQ_HALF = 0;
  localparam int IRQ_WRAP = 1;
  localparam int IRQ_WAVE = 3;

  // ----------------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [23:0] REG_RESET     = 24'h00_0000;
  localparam logic [15:0] MODE_RESET    = 16'h0000;
  localparam logic [3:0]  IRQ_EN_RESET  = 4'h0;
  localparam int          STEP_CYCLES   = 4;
  localparam int          WAVE_BASE_DIV = 128;
  localparam int          CAL_PULSE_CYC = 16;

endpackage

// ---- core/aeac_irq.sv ----
// Purpose: sticky interrupt status with enable mask and one level output
// Assumes: set and clear arrive on the same clock
// Notes:   a set in the cycle of its clear keeps the bit set
module aeac_irq #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  // events and software access
  input  wire logic [W-1:0] event_set,
  input  wire logic         clear_wr,
  input  wire logic [W-1:0] clear_bits,
  input  wire logic [W-1:0] enable,
  // results
  output logic      [W-1:0] status_q,
  output logic              irq
);

  // ----------------------------------------------------------------------
  // sticky bits, write one to clear
  // ----------------------------------------------------------------------
  // set is or-ed after the clear so that a late event is never lost
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~(clear_wr ? clear_bits : '0)) | event_set;
    end
  end

  // level output, high while an enabled bit stands
  assign irq = |(status_q & enable);

endmodule

// ---- core/aeac_pulse.sv ----
// Purpose: scales internal energy pulses down to the calibration output pulse
// Assumes: scaling factors already have the zero and clamp fixes applied
// Notes:   credit carries over, so bursts are spread at one output per pulse slot
module aeac_pulse #(
  parameter int CNT_W   = 12,
  parameter int RATIO_W = 13,
  parameter int PULSE_W = 16
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  // internal pulse count of one step
  input  wire logic               cnt_valid,
  input  wire logic [CNT_W-1:0]   cnt_in,
  // scaling, numerator plus one and denominator plus one
  input  wire logic [RATIO_W-1:0] num_p1,
  input  wire logic [RATIO_W-1:0] den_p1,
  // calibration output
  output logic                    pulse_o
);

  localparam int CRED_W = CNT_W + RATIO_W + 2;
  localparam int LEN_W  = $clog2(PULSE_W + 1);

  logic [CRED_W-1:0] credit_q;
  logic [CRED_W-1:0] credit_d;
  logic [LEN_W-1:0]  len_q;
  logic              fire;

  generate
    if (PULSE_W < 2) begin : g_chk
      $error("aeac_pulse: PULSE_W must be at least 2");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // credit: each internal pulse adds num+1, each output costs den+1
  // ----------------------------------------------------------------------
  assign fire = (len_q == '0) && (credit_q >= CRED_W'(den_p1));

  always_comb begin
    credit_d = credit_q;
    if (cnt_valid) begin
      credit_d = credit_d + CRED_W'(cnt_in * num_p1);
    end
    if (fire) begin
      credit_d = credit_d - CRED_W'(den_p1);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      credit_q <= '0;
    end else begin
      credit_q <= credit_d;
    end
  end

  // output pulse of fixed length, one at a time
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      len_q   <= '0;
      pulse_o <= 1'b0;
    end else begin
      if (fire) begin
        len_q   <= LEN_W'(PULSE_W);
        pulse_o <= 1'b1;
      end else if (len_q != '0) begin
        len_q   <= len_q - LEN_W'(1);
        pulse_o <= (len_q > LEN_W'(PULSE_W / 2));
      end else begin
        pulse_o <= 1'b0;
      end
    end
  end

endmodule

// ---- core/aeac_top.sv ----
// Purpose: active energy accumulator with divider, offset, gain and pulse output
// Assumes: power_in comes from logic on clk_sys and is held valid every cycle
// Notes:   one accumulation step every four clocks, three-stage pipeline
module aeac_top #(
  parameter int POWER_W = 24,
  parameter int PULSE_W = aeac_pkg::CAL_PULSE_CYC
) (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        reset_n,
  // active power stream
  input  wire logic signed [POWER_W-1:0]   power_in,
  // register port
  input  wire logic [aeac_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [aeac_pkg::DATA_W-1:0] reg_wr_data,
  input  wire logic                        reg_wr_en,
  input  wire logic                        reg_rd_en,
  output logic      [aeac_pkg::DATA_W-1:0] reg_rd_data,
  // outputs
  output logic                             irq,
  output logic                             calib_freq_pulse
);

  localparam int ACC_W   = aeac_pkg::ACC_W;
  localparam int EW      = aeac_pkg::ENERGY_W;
  localparam int GAINED_W = POWER_W + 2;
  localparam int SCALED_W = GAINED_W + aeac_pkg::OFS_FRAC + 1;
  localparam int DCNT_W  = 12;

  generate
    if (POWER_W < 8 || POWER_W > 32) begin : g_chk
      $error("aeac_top: POWER_W must lie in 8..32");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [aeac_pkg::DIV_W-1:0]          divisor_q;
  logic signed [aeac_pkg::OFFSET_W-1:0] offset_q;
  logic [aeac_pkg::SCALE_W-1:0]        num_q;
  logic [aeac_pkg::SCALE_W-1:0]        den_q;
  logic signed [aeac_pkg::GAIN_W-1:0]  gain_q;
  logic [15:0]                         mode_q;
  logic [aeac_pkg::IRQ_W-1:0]          irq_en_q;
  logic [aeac_pkg::IRQ_W-1:0]          irq_status;
  logic [EW-1:0]                       wave_q;

  logic rd_clear;
  logic rd_keep;
  logic wr_sel;
  assign rd_clear = reg_rd_en && (reg_addr == aeac_pkg::ADDR_ENERGY_CLR);
  assign rd_keep  = reg_rd_en && (reg_addr == aeac_pkg::ADDR_ENERGY_KEEP);
  assign wr_sel   = reg_wr_en;

  // software writes, one register per address
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      divisor_q <= aeac_pkg::REG_RESET[aeac_pkg::DIV_W-1:0];
      offset_q  <= aeac_pkg::REG_RESET[aeac_pkg::OFFSET_W-1:0];
      num_q     <= aeac_pkg::REG_RESET[aeac_pkg::SCALE_W-1:0];
      den_q     <= aeac_pkg::REG_RESET[aeac_pkg::SCALE_W-1:0];
      gain_q    <= aeac_pkg::REG_RESET[aeac_pkg::GAIN_W-1:0];
      mode_q    <= aeac_pkg::MODE_RESET;
      irq_en_q  <= aeac_pkg::IRQ_EN_RESET;
    end else if (wr_sel) begin
      case (reg_addr)
        aeac_pkg::ADDR_DIVISOR:     divisor_q <= reg_wr_data[aeac_pkg::DIV_W-1:0];
        aeac_pkg::ADDR_OFFSET:      offset_q  <= reg_wr_data[aeac_pkg::OFFSET_W-1:0];
        aeac_pkg::ADDR_NUMERATOR:   num_q     <= reg_wr_data[aeac_pkg::SCALE_W-1:0];
        aeac_pkg::ADDR_DENOMINATOR: den_q     <= reg_wr_data[aeac_pkg::SCALE_W-1:0];
        aeac_pkg::ADDR_GAIN:        gain_q    <= reg_wr_data[aeac_pkg::GAIN_W-1:0];
        aeac_pkg::ADDR_MODE:        mode_q    <= reg_wr_data[15:0];
        aeac_pkg::ADDR_IRQ_ENABLE:  irq_en_q  <= reg_wr_data[aeac_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // step sequencer: capture, divide, accumulate
  // ----------------------------------------------------------------------
  logic [1:0] phase_q;
  logic       cap_en;
  logic       div_en;
  logic       acc_en;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign cap_en = (phase_q == 2'h0);
  assign div_en = (phase_q == 2'h1);
  assign acc_en = (phase_q == 2'h2);

  // ----------------------------------------------------------------------
  // datapath: gain, offset, divider
  // ----------------------------------------------------------------------
  logic signed [GAINED_W-1:0] gained_q;
  logic signed [GAINED_W+15:0] gain_prod;
  logic signed [14:0]          gain_mult;
  logic signed [SCALED_W-1:0]  scaled;
  logic signed [SCALED_W-1:0]  divided;
  logic signed [SCALED_W-1:0]  addend_q;
  logic signed [ACC_W-1:0]     addend_ext;
  logic [aeac_pkg::DIV_W:0]    div_eff;

  // 4096 + gain, always positive for a 12-bit signed gain
  assign gain_mult = 15'sh1000 + 15'(gain_q);
  assign gain_prod = (GAINED_W+16)'(power_in * gain_mult);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gained_q <= '0;
    end else if (cap_en) begin
      gained_q <= GAINED_W'(gain_prod >>> aeac_pkg::GAIN_FRAC);
    end
  end

  // offset carries eight fraction bits, so the whole path keeps them
  assign scaled  = (SCALED_W'(gained_q) <<< aeac_pkg::OFS_FRAC)
                 + SCALED_W'(offset_q);
  assign div_eff = (divisor_q == '0) ? 9'h001 : {1'b0, divisor_q};
  // a single-cycle divide trades area for a simple fixed-latency step
  assign divided = scaled / $signed({1'b0, div_eff});

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      addend_q <= '0;
    end else if (div_en) begin
      addend_q <= divided;
    end
  end

  assign addend_ext = ACC_W'(addend_q);

  // ----------------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------------
  logic signed [ACC_W-1:0] acc_q;
  logic signed [ACC_W-1:0] acc_base;
  logic signed [ACC_W-1:0] acc_d;
  logic signed [ACC_W-1:0] acc_sum;

  // the clearing read only zeroes the upper half; the step still adds
  assign acc_base = rd_clear ? {{EW{1'b0}}, acc_q[ACC_W-EW-1:0]} : acc_q;
  assign acc_sum  = acc_base + addend_ext;
  assign acc_d    = acc_en ? acc_sum : acc_base;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ----------------------------------------------------------------------
  // energy events and internal pulse count
  // ----------------------------------------------------------------------
  logic [EW-1:0]     up_old;
  logic [EW-1:0]     up_new;
  logic [EW-1:0]     up_delta;
  logic [EW-1:0]     up_mag;
  logic [DCNT_W-1:0] pulse_cnt;
  logic              half_evt;
  logic              wrap_evt;

  assign up_old = acc_base[ACC_W-1:ACC_W-EW];
  assign up_new = acc_sum[ACC_W-1:ACC_W-EW];
  // crossing of 400000h upward or C00000h downward
  assign half_evt = acc_en && (up_old[EW-1] == up_new[EW-1])
                  && (up_old[EW-2] != up_new[EW-2]) && (up_new[EW-2] != up_new[EW-1]);
  // sign flip in the direction of the addend
  assign wrap_evt = acc_en && (up_old[EW-1] != up_new[EW-1])
                  && (up_old[EW-1] == addend_q[SCALED_W-1]);

  assign up_delta = up_new - up_old;
  assign up_mag   = up_delta[EW-1] ? (~up_delta + 24'h00_0001) : up_delta;
  assign pulse_cnt = (up_mag > EW'((1 << DCNT_W) - 1)) ? '1 : up_mag[DCNT_W-1:0];

  // ----------------------------------------------------------------------
  // waveform sampling
  // ----------------------------------------------------------------------
  logic [9:0] wave_cnt_q;
  logic [9:0] wave_top;
  logic       wave_tick;
  logic       wave_on;
  logic       wave_evt;

  assign wave_top  = 10'((aeac_pkg::WAVE_BASE_DIV << mode_q[aeac_pkg::MODE_RATE_LO +: 2]) - 1);
  assign wave_tick = (wave_cnt_q >= wave_top);
  assign wave_on   = (mode_q[aeac_pkg::MODE_SEL_LO +: 2] == aeac_pkg::WAVE_SEL_POWER)
                   && irq_en_q[aeac_pkg::IRQ_WAVE];
  assign wave_evt  = wave_tick && wave_on;

  // rate divider, 128 to 1024 clocks per sample
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wave_cnt_q <= 10'h000;
    end else begin
      wave_cnt_q <= wave_tick ? 10'h000 : wave_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wave_q <= '0;
    end else if (wave_evt) begin
      wave_q <= EW'(gained_q);
    end
  end

  // ----------------------------------------------------------------------
  // interrupts and calibration pulse
  // ----------------------------------------------------------------------
  logic [aeac_pkg::IRQ_W-1:0] irq_set;
  logic [12:0]                num_p1;
  logic [12:0]                den_p1;
  logic [11:0]                num_use;
  logic [11:0]                den_use;
  logic [11:0]                num_eff;

  assign irq_set = {wave_evt, 1'b0, wrap_evt, half_evt};

  aeac_irq #(
    .W          (aeac_pkg::IRQ_W)
  ) u_irq (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .event_set  (irq_set),
    .clear_wr   (reg_wr_en && (reg_addr == aeac_pkg::ADDR_IRQ_STATUS)),
    .clear_bits (reg_wr_data[aeac_pkg::IRQ_W-1:0]),
    .enable     (irq_en_q),
    .status_q   (irq_status),
    .irq        (irq)
  );

  assign num_use = (num_q == '0) ? 12'h001 : num_q;
  assign den_use = (den_q == '0) ? 12'h001 : den_q;
  assign num_eff = (num_use > den_use) ? den_use : num_use;
  assign num_p1  = {1'b0, num_eff} + 13'h0001;
  assign den_p1  = {1'b0, den_use} + 13'h0001;

  aeac_pulse #(
    .CNT_W     (DCNT_W),
    .RATIO_W   (13),
    .PULSE_W   (PULSE_W)
  ) u_pulse (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .cnt_valid (acc_en),
    .cnt_in    (pulse_cnt),
    .num_p1    (num_p1),
    .den_p1    (den_p1),
    .pulse_o   (calib_freq_pulse)
  );

  // ----------------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rd_data <= '0;
    end else if (reg_rd_en) begin
      case (reg_addr)
        aeac_pkg::ADDR_ENERGY_CLR:  reg_rd_data <= acc_q[ACC_W-1:ACC_W-EW];
        aeac_pkg::ADDR_ENERGY_KEEP: reg_rd_data <= acc_q[ACC_W-1:ACC_W-EW];
        aeac_pkg::ADDR_DIVISOR:     reg_rd_data <= 24'(divisor_q);
        aeac_pkg::ADDR_OFFSET:      reg_rd_data <= 24'($unsigned(offset_q));
        aeac_pkg::ADDR_NUMERATOR:   reg_rd_data <= 24'(num_q);
        aeac_pkg::ADDR_DENOMINATOR: reg_rd_data <= 24'(den_q);
        aeac_pkg::ADDR_GAIN:        reg_rd_data <= 24'($unsigned(gain_q));
        aeac_pkg::ADDR_MODE:        reg_rd_data <= 24'(mode_q);
        aeac_pkg::ADDR_IRQ_STATUS:  reg_rd_data <= 24'(irq_status);
        aeac_pkg::ADDR_IRQ_ENABLE:  reg_rd_data <= 24'(irq_en_q);
        aeac_pkg::ADDR_WAVEFORM:    reg_rd_data <= wave_q;
        default:                    reg_rd_data <= '0;
      endcase
    end else begin
      reg_rd_data <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_step_period: assert property (acc_en |=> !acc_en [*3] ##1 acc_en)
    else $error("accumulation step not every four clocks");
  a_accum_add: assert property (acc_en && !rd_clear |=> acc_q == $past(acc_q) + $past(addend_ext))
    else $error("signed step addition wrong");
  a_clear_read: assert property (rd_clear && !acc_en |=> acc_q[47:24] == 24'h00_0000)
    else $error("upper energy not cleared by read");
  a_clear_keeps: assert property (rd_clear && acc_en |=>
      acc_q == {24'h00_0000, $past(acc_q[23:0])} + $past(addend_ext))
    else $error("step lost on clearing read");
  a_keep_read: assert property (rd_keep && !acc_en |=>
      acc_q == $past(acc_q) && reg_rd_data == $past(acc_q[47:24]))
    else $error("non-clearing read disturbed energy");
  a_div_one: assert property (div_en && divisor_q == 8'h00 |=> addend_q == $past(scaled))
    else $error("zero divisor not division by one");
  a_ratio_clamp: assert property (num_p1 <= den_p1 && num_p1 >= 13'h0002)
    else $error("scaling ratio above one or zero not replaced");
  a_wrap_flag: assert property (wrap_evt |=> irq_status[1])
    else $error("wrap event not flagged");
  a_irq_enable: assert property (irq_status == 4'h0 |-> !irq)
    else $error("interrupt without status");
  a_wave_hold: assert property (!wave_on |=> $stable(wave_q))
    else $error("waveform updated while disabled");
  a_pulse_output: assert property ($rose(calib_freq_pulse) |-> ##[1:16] !calib_freq_pulse)
    else $error("calibration pulse never ends");

  c_wrap: cover property (wrap_evt);
  c_half: cover property (half_evt);
  c_clear_step: cover property (rd_clear && acc_en);
  c_cal_pulse: cover property ($rose(calib_freq_pulse));

endmodule

// ---- verification/aeac_cal_counter.sv ----
// Purpose: calibration equipment model counting calibration output pulses
// Assumes: pulse output is synchronous to clk_sys
// Notes:   counts rising edges only, so a wide pulse counts once
module aeac_cal_counter (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // pulse input and gate restart
  input  wire logic        pulse_in,
  input  wire logic        clear,
  output logic      [15:0] count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q;
  // gate counter, restarted by the bench before each measurement
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= 1'b0;
      count  <= 16'h0000;
    end else begin
      prev_q <= pulse_in;
      if (clear) begin
        count <= 16'h0000;
      end else if (pulse_in && !prev_q) begin
        count <= count + 16'h0001;
      end
    end
  end
endmodule

// ---- verification/aeac_top_tb.sv ----
// Purpose: self-checking bench for the energy accumulator block
// Assumes: 250 MHz clock, register reads answer one cycle later
// Notes:   energy rates are measured as the change over 40 clocks
module aeac_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_sys, reset_n, reg_wr_en, reg_rd_en, cal_clear;
  logic signed [23:0] power_in;
  logic        [3:0]  reg_addr;
  logic        [23:0] reg_wr_data, reg_rd_data, va, vb;
  logic               irq, calib_freq_pulse;
  logic        [15:0] cal_count;
  int                 error_cnt, checked, cycles;

  aeac_top #(.POWER_W(24)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .power_in(power_in), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .irq(irq), .calib_freq_pulse(calib_freq_pulse));
  aeac_cal_counter u_cal (.clk_sys(clk_sys), .reset_n(reset_n),
    .pulse_in(calib_freq_pulse), .clear(cal_clear), .count(cal_count));

  // ----------------------------------------------------------------------
  // clock, hang guard and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // whole run needs about 2800 clocks, so 20000 means a hang
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("[ERR] run_cycles exp below 20000 got %0d", cycles);
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk_sys);
    reg_wr_en   <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge clk_sys);
    reg_wr_en   <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    @(posedge clk_sys);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1 d = reg_rd_data;
  endtask
  task automatic setp(input logic [23:0] pw, g, o, dv);
    wr(4'h6, g);
    wr(4'h3, o);
    wr(4'h2, dv);
    power_in <= pw;
    repeat (20) @(posedge clk_sys);
  endtask
  // any 40-clock span holds exactly ten accumulation steps
  task automatic rate(input logic [23:0] pw, g, o, dv, e);
    setp(pw, g, o, dv);
    rd(4'h1, va);
    repeat (38) @(posedge clk_sys);
    rd(4'h1, vb);
    chk("energy_rate", e, vb - va);
  endtask
  task automatic calib(input logic [23:0] n, d, pw, input logic [15:0] lo, hi);
    // fresh reset empties pulse credit left over from earlier tests
    power_in <= '0;
    reset_n  <= 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_n  <= 1'b1;
    wr(4'h4, n);
    wr(4'h5, d);
    setp(pw, 24'h00_0000, 24'h00_0000, 24'h00_0000);
    repeat (80) @(posedge clk_sys);
    cal_clear <= 1'b1;
    @(posedge clk_sys);
    cal_clear <= 1'b0;
    repeat (640) @(posedge clk_sys);
    chk("cf_count_in_range", 24'h00_0001, 24'(cal_count >= lo && cal_count <= hi));
  endtask

  // ----------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    power_in = '0;
    reg_addr = '0;
    reg_wr_data = '0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    cal_clear = 1'b0;
    error_cnt = 0;
    checked = 0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    // every address, unmapped ones included, reads zero out of reset
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], va);
      chk("reset_value", 24'h00_0000, va);
    end
    wr(4'h1, 24'h12_3456);
    rd(4'h1, va);
    chk("energy_read_only", 24'h00_0000, va);
    wr(4'h2, 24'hFF_FFA5);
    rd(4'h2, va);
    chk("divisor", 24'h00_00A5, va);
    wr(4'h4, 24'hFF_FFFF);
    rd(4'h4, va);
    chk("numerator", 24'h00_0FFF, va);
    wr(4'h3, 24'hFF_8001);
    rd(4'h3, va);
    chk("offset", 24'h00_8001, va);
    $display("test registers done");
    rate(24'h01_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_000A);
    rate(24'hFF_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000, 24'hFF_FFF6);
    rate(24'h01_0000, 24'h00_0000, 24'h00_0000, 24'h00_0002, 24'h00_0005);
    rate(24'h01_0000, 24'h00_0800, 24'h00_0000, 24'h00_0000, 24'h00_0005);
    rate(24'h00_FFFF, 24'h00_0000, 24'h00_0100, 24'h00_0000, 24'h00_000A);
    $display("test accumulate done");
    setp(24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000);
    rd(4'h1, va);
    rd(4'h0, vb);
    chk("clear_read_value", va, vb);
    rd(4'h1, va);
    chk("after_clear", 24'h00_0000, va);
    rate(24'h01_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_000A);
    // the shifts put the clearing read on only two of the four step phases
    for (int k = 0; k < 4; k++) begin
      repeat (k) @(posedge clk_sys);
      rd(4'h0, va);
      repeat (38) @(posedge clk_sys);
      rd(4'h1, vb);
      chk("clear_keeps_step", 24'h00_000A, vb);
    end
    $display("test clear_read done");
    wr(4'h7, 24'h00_0000);
    wr(4'h9, 24'h00_0008);
    repeat (300) @(posedge clk_sys);
    chk("irq_raised", 24'h00_0001, {23'h00_0000, irq});
    rd(4'hA, va);
    chk("waveform", 24'h01_0000, va);
    wr(4'h9, 24'h00_0000);
    rd(4'h8, va);
    chk("status_sticky", 24'h00_0008, va);
    chk("irq_masked", 24'h00_0000, {23'h00_0000, irq});
    wr(4'h8, 24'h00_0008);
    rd(4'h8, va);
    chk("status_cleared", 24'h00_0000, va);
    // another source select must leave the waveform and its flag alone
    power_in <= 24'h00_0123;
    wr(4'h7, 24'h00_2000);
    wr(4'h9, 24'h00_0008);
    repeat (300) @(posedge clk_sys);
    rd(4'hA, va);
    chk("waveform_other_sel", 24'h01_0000, va);
    rd(4'h8, va);
    chk("status_no_sample", 24'h00_0000, va);
    $display("test interrupt done");
    calib(24'h00_0000, 24'h00_000F, 24'h01_0000, 16'h0013, 16'h0015);
    calib(24'h00_000F, 24'h00_0000, 24'h00_1000, 16'h0009, 16'h000B);
    $display("test pulse done");
    summarize();
  end
endmodule
